//--- rtl/light_cycle_ctrl.sv
/*
  measurement cycle control of a colour / ambient light sensor:
  enable register, integration and wait down counters, long wait,
  channel-0 low threshold with byte latch, persistence and event pin.
  assumes the serial bus engine delivers byte reads and writes on the
  register port in the clk domain, and the converter holds its
  channel-0 count on chan0Count at the end of each integration.
*/
`timescale 1ns/100ps

// Contract
// - power-on bit starts and stops oscillator
// - wait-enable bit activates the wait timer
// - measure-enable bit turns on light measurement
// - measure and power-on together run autozero (code: only when both are set in one write while power-on was clear)
// - measurement only while power-on is set
// - integration length register, resets to zero
// - integration timer counts down to zero
// - counter decrements every 2.78 ms step
// - integration lasts value plus one steps
// - wait timer counts down to zero
// - wait lasts value plus one steps
// - long wait makes each step twelve times
// - low threshold low byte register, resets zero
// - long wait in config zero bit two
// - low byte latched until high byte written
// - below threshold after persistence sets event
module light_cycle_ctrl #(
  parameter int STEP_CYCLES = light_cycle_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // converter side
  input wire logic [15:0] chan0Count,
  output logic oscOn,
  output logic autoZeroing,
  output logic integrating,
  output logic waiting,
  output logic sampleTaken,
  // event pin, open drain
  output logic eventPinOut,
  output logic eventPinOe
);

  typedef struct packed {
    logic [7:0] enableReg;
    logic [7:0] intLength;
    logic [7:0] idleLength;
    logic [7:0] lowLatch;
    logic [15:0] lowThreshold;
    logic [3:0] persistence;
    logic [7:0] configZero;
    logic [7:0] eventEnable;
    logic threshEvent;
    logic [5:0] outCount;
    light_cycle_pkg::cycle_t phase;
    logic [31:0] prescale;
    logic [3:0] longCount;
    logic [7:0] downCount;
    logic [7:0] rdData;
    logic rdValid;
    logic sampled;
    logic pinOe;
    logic pinOut;
    logic inAutoZero;
    logic inIntegrate;
    logic inWait;
  } state_t;

  state_t st;
  state_t next_st;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // consecutive out-of-range results needed for an event
  function automatic logic [5:0] persistTarget(input logic [3:0] code);
    if (code < 4'h4) begin
      persistTarget = {2'b00, code};
    end else begin
      persistTarget = 6'(({2'b00, code} - 6'h03) * 6'h05);
    end
  endfunction

  // largest count an integration of the given length can give
  function automatic logic [15:0] fullScale(input logic [7:0] steps);
    logic [17:0] span;
    span = 18'(({10'h000, steps} + 18'h00001) * 18'(light_cycle_pkg::COUNTS_PER_STEP));
    if (span > 18'h0FFFF) begin
      fullScale = 16'hFFFF;
    end else begin
      fullScale = 16'(span - 18'h00001);
    end
  endfunction

  logic stepTick;
  logic powerOn;
  logic measureOn;
  logic [15:0] clamped;
  logic [5:0] target;
  logic eventSet;

  always_comb begin
    next_st = st;
    powerOn = st.enableReg[light_cycle_pkg::POWER_ON_BIT];
    measureOn = st.enableReg[light_cycle_pkg::MEASURE_EN_BIT];
    stepTick = 1'b0;
    clamped = chan0Count;
    target = persistTarget(st.persistence);
    eventSet = 1'b0;
    next_st.sampled = 1'b0;
    next_st.rdValid = 1'b0;

    // ------------------------------------------------------------
    // step prescaler
    // ------------------------------------------------------------
    // oscillator runs only with power-on
    if (!powerOn) begin
      next_st.prescale = 32'h00000000;
    end else if (st.prescale == 32'(STEP_CYCLES - 1)) begin
      next_st.prescale = 32'h00000000;
      stepTick = 1'b1;
    end else begin
      next_st.prescale = st.prescale + 32'h00000001;
    end

    // ------------------------------------------------------------
    // measurement cycle
    // ------------------------------------------------------------
    unique case (st.phase)
      light_cycle_pkg::CYC_IDLE: begin
        if (powerOn && measureOn) begin
          next_st.phase = light_cycle_pkg::CYC_INTEGRATE;
          next_st.downCount = st.intLength;
          next_st.prescale = 32'h00000000;
        end
      end
      light_cycle_pkg::CYC_AUTOZERO: begin
        if (stepTick) begin
          if (st.downCount == 8'h00) begin
            next_st.phase = light_cycle_pkg::CYC_INTEGRATE;
            next_st.downCount = st.intLength;
          end else begin
            next_st.downCount = st.downCount - 8'h01;
          end
        end
      end
      light_cycle_pkg::CYC_INTEGRATE: begin
        if (stepTick) begin
          if (st.downCount == 8'h00) begin
            if (chan0Count > fullScale(st.intLength)) begin
              clamped = fullScale(st.intLength);
            end
            next_st.sampled = 1'b1;
            if (clamped < st.lowThreshold) begin
              if (st.outCount != 6'h3F) begin
                next_st.outCount = st.outCount + 6'h01;
              end
              if (st.outCount + 6'h01 >= target) begin
                next_st.threshEvent = 1'b1;
                eventSet = 1'b1;
              end
            end else begin
              next_st.outCount = 6'h00;
              if (st.persistence == 4'h0) begin
                next_st.threshEvent = 1'b1;
                eventSet = 1'b1;
              end
            end
            if (st.enableReg[light_cycle_pkg::WAIT_EN_BIT]) begin
              next_st.phase = light_cycle_pkg::CYC_WAIT;
              next_st.downCount = st.idleLength;
              next_st.longCount = 4'h0;
            end else begin
              next_st.downCount = st.intLength;
            end
          end else begin
            next_st.downCount = st.downCount - 8'h01;
          end
        end
      end
      light_cycle_pkg::CYC_WAIT: begin
        if (stepTick) begin
          if (st.configZero[light_cycle_pkg::LONG_WAIT_BIT] &&
              st.longCount != light_cycle_pkg::LONG_WAIT_FACTOR - 4'h1) begin
            next_st.longCount = st.longCount + 4'h1;
          end else begin
            next_st.longCount = 4'h0;
            if (st.downCount == 8'h00) begin
              next_st.phase = light_cycle_pkg::CYC_INTEGRATE;
              next_st.downCount = st.intLength;
            end else begin
              next_st.downCount = st.downCount - 8'h01;
            end
          end
        end
      end
    endcase

    if (!powerOn || !measureOn) begin
      next_st.phase = light_cycle_pkg::CYC_IDLE;
      next_st.downCount = 8'h00;
      next_st.longCount = 4'h0;
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    if (regWrite) begin
      unique case (regAddr)
        light_cycle_pkg::FUNCTION_ENABLE_CTRL: begin
          next_st.enableReg = regWrData;
          // both set in one write while power-on was clear: autozero first
          if (regWrData[light_cycle_pkg::POWER_ON_BIT] &&
              regWrData[light_cycle_pkg::MEASURE_EN_BIT]) begin
            if (!powerOn) begin
              next_st.phase = light_cycle_pkg::CYC_AUTOZERO;
              next_st.downCount = light_cycle_pkg::AUTOZERO_STEPS - 8'h01;
              next_st.prescale = 32'h00000000;
            end
          end else begin
            next_st.phase = light_cycle_pkg::CYC_IDLE;
            next_st.downCount = 8'h00;
            next_st.longCount = 4'h0;
          end
        end
        light_cycle_pkg::INTEGRATION_LENGTH: next_st.intLength = regWrData;
        light_cycle_pkg::IDLE_INTERVAL_LENGTH: next_st.idleLength = regWrData;
        light_cycle_pkg::LOW_THRESHOLD_LSB: next_st.lowLatch = regWrData;
        light_cycle_pkg::LOW_THRESHOLD_MSB: next_st.lowThreshold = {regWrData, st.lowLatch};
        light_cycle_pkg::PERSISTENCE_CTRL: next_st.persistence = regWrData[3:0];
        light_cycle_pkg::CONFIG_ZERO: next_st.configZero = regWrData;
        light_cycle_pkg::EVENT_ENABLE: next_st.eventEnable = regWrData;
        light_cycle_pkg::EVENT_STATUS: begin
          // write one clears, a new event in the same cycle wins
          if (regWrData[light_cycle_pkg::THRESH_EVENT_BIT] && !eventSet) begin
            next_st.threshEvent = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    if (regRead) begin
      next_st.rdValid = 1'b1;
      unique case (regAddr)
        light_cycle_pkg::FUNCTION_ENABLE_CTRL: next_st.rdData = st.enableReg;
        light_cycle_pkg::INTEGRATION_LENGTH: next_st.rdData = st.intLength;
        light_cycle_pkg::IDLE_INTERVAL_LENGTH: next_st.rdData = st.idleLength;
        light_cycle_pkg::LOW_THRESHOLD_LSB: next_st.rdData = st.lowLatch;
        light_cycle_pkg::LOW_THRESHOLD_MSB: next_st.rdData = st.lowThreshold[15:8];
        light_cycle_pkg::PERSISTENCE_CTRL: next_st.rdData = {4'h0, st.persistence};
        light_cycle_pkg::CONFIG_ZERO: next_st.rdData = st.configZero;
        light_cycle_pkg::EVENT_ENABLE: next_st.rdData = st.eventEnable;
        light_cycle_pkg::EVENT_STATUS: next_st.rdData = 8'({st.threshEvent, 4'h0});
        default: next_st.rdData = 8'h00;
      endcase
    end

    // pin pulled low when enabled event
    next_st.pinOe = next_st.threshEvent &
                    next_st.eventEnable[light_cycle_pkg::THRESH_IRQ_EN_BIT];
    next_st.pinOut = 1'b0;
    // phase flags held in flops for the outputs
    next_st.inAutoZero = (next_st.phase == light_cycle_pkg::CYC_AUTOZERO);
    next_st.inIntegrate = (next_st.phase == light_cycle_pkg::CYC_INTEGRATE);
    next_st.inWait = (next_st.phase == light_cycle_pkg::CYC_WAIT);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.enableReg <= light_cycle_pkg::ENABLE_RESET;
      st.intLength <= light_cycle_pkg::STEPS_RESET;
      st.idleLength <= light_cycle_pkg::STEPS_RESET;
      st.configZero <= light_cycle_pkg::CONFIG_ZERO_RESET;
      st.phase <= light_cycle_pkg::CYC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign regRdData = st.rdData;
  assign regRdValid = st.rdValid;
  assign oscOn = st.enableReg[light_cycle_pkg::POWER_ON_BIT];
  assign autoZeroing = st.inAutoZero;
  assign integrating = st.inIntegrate;
  assign waiting = st.inWait;
  assign sampleTaken = st.sampled;
  assign eventPinOut = st.pinOut;
  assign eventPinOe = st.pinOe;

endmodule

//--- rtl/light_cycle_pkg.sv
/*
  constants for the light sensor cycle control: register offsets,
  field positions, reset values and step timing.
  assumes a 10 MHz core clock and byte-wide register access.
*/
package light_cycle_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] FUNCTION_ENABLE_CTRL = 8'h80;
  localparam logic [7:0] INTEGRATION_LENGTH = 8'h81;
  localparam logic [7:0] IDLE_INTERVAL_LENGTH = 8'h83;
  localparam logic [7:0] LOW_THRESHOLD_LSB = 8'h84;
  localparam logic [7:0] LOW_THRESHOLD_MSB = 8'h85;
  localparam logic [7:0] PERSISTENCE_CTRL = 8'h8C;
  localparam logic [7:0] CONFIG_ZERO = 8'h8D;
  localparam logic [7:0] EVENT_STATUS = 8'h93;
  localparam logic [7:0] EVENT_ENABLE = 8'hDD;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] STEPS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_ZERO_RESET = 8'h80;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int POWER_ON_BIT = 0;
  localparam int MEASURE_EN_BIT = 1;
  localparam int WAIT_EN_BIT = 3;
  localparam int LONG_WAIT_BIT = 2;
  localparam int THRESH_EVENT_BIT = 4;
  localparam int THRESH_IRQ_EN_BIT = 4;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_TIME_NS = 2780000;
  localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [3:0] LONG_WAIT_FACTOR = 4'hC;
  localparam logic [7:0] AUTOZERO_STEPS = 8'h01;
  localparam int COUNTS_PER_STEP = 1024;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_AUTOZERO = 2'b01,
    CYC_INTEGRATE = 2'b10,
    CYC_WAIT = 2'b11
  } cycle_t;

endpackage

//--- tb/light_cycle_ctrl_props.sv
/*
  port checker for the light cycle control block.
  assumes it is bound to every light_cycle_ctrl with the same STEP_CYCLES.
*/
`timescale 1ns/100ps
module light_cycle_ctrl_props #(
  parameter int STEP_CYCLES = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  // converter side
  input wire logic [15:0] chan0Count,
  input wire logic oscOn,
  input wire logic autoZeroing,
  input wire logic integrating,
  input wire logic waiting,
  input wire logic sampleTaken,
  // event pin
  input wire logic eventPinOut,
  input wire logic eventPinOe
);
  // ------------------------------------------------------------
  // tracking of phase runs and written fields
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] last;
    logic [15:0] run;
    logic [7:0] intLen;
    logic [7:0] idleLen;
    logic longW;
    logic wen;
    logic evEn;
  } trk_t;
  trk_t cur;
  trk_t next_cur;
  logic [2:0] phase;
  logic enWrite;
  assign phase = {autoZeroing, integrating, waiting};
  assign enWrite = regWrite && regAddr == 8'h80;
  always_comb begin
    next_cur = cur;
    next_cur.last = phase;
    next_cur.run = (phase == cur.last) ? cur.run + 16'h1 : 16'h1;
    if (regWrite) begin
      case (regAddr)
        8'h80: next_cur.wen = regWrData[3];
        8'h81: next_cur.intLen = regWrData;
        8'h83: next_cur.idleLen = regWrData;
        8'h8D: next_cur.longW = regWrData[2];
        8'hDD: next_cur.evEn = regWrData[4];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cur <= '0;
    else cur <= next_cur;
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence az_ends_s;
    integrating && $past(autoZeroing);
  endsequence
  sequence direct_start_s;
    !autoZeroing ##1 (integrating && !autoZeroing);
  endsequence
  chk_osc_follows_bit: assert property (enWrite |=> oscOn == $past(regWrData[0]))
    else $error("oscillator does not follow power bit");
  chk_wait_enabled: assert property ($rose(waiting) |-> cur.wen)
    else $error("wait phase without wait enable");
  chk_autozero_first: assert property (
    enWrite && regWrData[1:0] == 2'b11 && !oscOn |=> autoZeroing && !integrating)
    else $error("no autozero after joint enable");
  chk_no_autozero: assert property (
    enWrite && regWrData[1:0] == 2'b11 && oscOn && phase == 3'h0 |=> direct_start_s)
    else $error("autozero while already powered");
  chk_autozero_len: assert property (az_ends_s |-> cur.run == STEP_CYCLES)
    else $error("autozero length wrong");
  chk_unpowered_idle: assert property (!oscOn |-> phase == 3'h0)
    else $error("phase active without power");
  chk_integ_len: assert property (
    waiting && $past(integrating) |-> cur.run == 16'((cur.intLen + 1) * STEP_CYCLES))
    else $error("integration length wrong");
  chk_wait_len: assert property (
    integrating && $past(waiting)
    |-> cur.run == 16'((cur.idleLen + 1) * STEP_CYCLES * (cur.longW ? 12 : 1)))
    else $error("wait length wrong");
  chk_sample_pulse: assert property (sampleTaken |=> !sampleTaken)
    else $error("sample pulse too long");
  chk_pin_gated: assert property (eventPinOe |-> cur.evEn && !eventPinOut)
    else $error("event pin driven while disabled");
  chk_read_answer: assert property (regRead |=> regRdValid)
    else $error("read not answered");
endmodule

bind light_cycle_ctrl light_cycle_ctrl_props #(.STEP_CYCLES(STEP_CYCLES)) i_light_cycle_ctrl_props (
  .clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
  .chan0Count(chan0Count), .oscOn(oscOn), .autoZeroing(autoZeroing),
  .integrating(integrating), .waiting(waiting), .sampleTaken(sampleTaken),
  .eventPinOut(eventPinOut), .eventPinOe(eventPinOe));

//--- tb/host_bus_model.sv
/*
  host side of the byte register port: write and read cycles.
  assumes strobes are taken on the rising edge of clk.
*/
`timescale 1ns/100ps
module host_bus_model (
  // clock
  input wire logic clk,
  // register port
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  task automatic readReg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    v = regRdValid;
    d = regRdData;
  endtask
endmodule

//--- tb/light_sensor_cycle_control_tb_top.sv
/*
  testbench for the light cycle control block.
  assumes STEP_CYCLES cut to 4 clocks per step.
*/
`timescale 1ns/100ps
module light_sensor_cycle_control_tb_top;
  localparam int STEP = 4;
  logic clk, rst, regWrite, regRead, regRdValid, oscOn, autoZeroing;
  logic integrating, waiting, sampleTaken, eventPinOut, eventPinOe;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [15:0] chan0Count;
  logic [2:0] phase;
  int n_mismatch, n_checks, n;
  assign phase = {autoZeroing, integrating, waiting};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  light_cycle_ctrl #(.STEP_CYCLES(STEP)) i_light_cycle_ctrl (
    .clk(clk), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .chan0Count(chan0Count), .oscOn(oscOn), .autoZeroing(autoZeroing),
    .integrating(integrating), .waiting(waiting), .sampleTaken(sampleTaken),
    .eventPinOut(eventPinOut), .eventPinOe(eventPinOe));
  host_bus_model i_host_bus_model (
    .clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_bus_model.writeReg(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_host_bus_model.readReg(a, d, v);
    check("read valid", {15'h0, v}, 16'h1);
    check("read data", {8'h00, d}, {8'h00, e});
  endtask
  task automatic runOf(input logic [2:0] p, output int len);
    int g;
    g = 0;
    len = 0;
    while (phase !== p && g < 2000) begin
      @(negedge clk);
      g++;
    end
    while (phase === p && len < 2000) begin
      @(negedge clk);
      len++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_registers();
    logic [7:0] addrs [6] = '{8'h80, 8'h81, 8'h83, 8'h84, 8'h8D, 8'h82};
    logic [7:0] resets [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rd(addrs[i], resets[i]);
    end
    wr(8'h81, 8'h01);
    wr(8'h83, 8'h01);
    wr(8'h84, 8'h5A);
    rd(8'h81, 8'h01);
    rd(8'h83, 8'h01);
    rd(8'h84, 8'h5A);
    $display("test registers done");
  endtask
  task automatic test_cycle();
    wr(8'h8C, 8'h00);
    wr(8'hDD, 8'h10);
    wr(8'h84, 8'hFF);
    wr(8'h85, 8'hFF);
    wr(8'h80, 8'h0B);
    runOf(3'b100, n);
    check("autozero run", 16'(n), 16'(STEP));
    runOf(3'b010, n);
    check("integrate run", 16'(n), 16'(2 * STEP));
    runOf(3'b001, n);
    check("wait run", 16'(n), 16'(2 * STEP));
    check("osc on", {15'h0, oscOn}, 16'h1);
    check("event pin", {14'h0, eventPinOe, eventPinOut}, 16'h2);
    $display("test cycle done");
  endtask
  task automatic test_long_wait();
    wr(8'h80, 8'h00);
    wr(8'h8D, 8'h84);
    wr(8'h80, 8'h0B);
    runOf(3'b010, n);
    runOf(3'b001, n);
    check("long wait run", 16'(n), 16'(24 * STEP));
    $display("test long wait done");
  endtask
  task automatic test_no_wait();
    logic [2:0] seen;
    int samples;
    seen = 3'h0;
    samples = 0;
    wr(8'h80, 8'h00);
    wr(8'h80, 8'h01);
    wr(8'h80, 8'h03);
    repeat (36) begin
      @(negedge clk);
      seen = seen | (phase & 3'b101);
      samples += int'(sampleTaken === 1'b1);
    end
    check("autozero or wait", {13'h0, seen}, 16'h0);
    check("samples", 16'(samples), 16'h0004);
    $display("test no wait done");
  endtask
  task automatic test_power_off();
    logic [3:0] acc;
    acc = 4'h0;
    wr(8'h80, 8'h02);
    repeat (20) begin
      @(negedge clk);
      acc = acc | {oscOn, phase};
    end
    check("unpowered", {12'h0, acc}, 16'h0);
    $display("test power off done");
  endtask
  task automatic test_threshold();
    wr(8'h80, 8'h00);
    wr(8'h8C, 8'h01);
    wr(8'h84, 8'h00);
    wr(8'h85, 8'h00);
    wr(8'h93, 8'h10);
    // low byte alone must not apply
    wr(8'h84, 8'h20);
    wr(8'h80, 8'h03);
    repeat (16) @(negedge clk);
    check("latched only", {15'h0, eventPinOe}, 16'h0000);
    wr(8'h85, 8'h00);
    repeat (16) @(negedge clk);
    check("below low", {15'h0, eventPinOe}, 16'h0001);
    wr(8'h80, 8'h00);
    wr(8'h93, 8'h10);
    wr(8'h85, 8'h08);
    chan0Count <= 16'hFFFF;
    wr(8'h80, 8'h03);
    repeat (16) @(negedge clk);
    check("full scale", {15'h0, eventPinOe}, 16'h0001);
    rd(8'h93, 8'h10);
    $display("test threshold done");
  endtask
  initial begin
    rst = 1'b1;
    chan0Count = 16'h0010;
    n_mismatch = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    test_registers();
    test_cycle();
    test_long_wait();
    test_no_wait();
    test_power_off();
    test_threshold();
    complete_run();
  end
  // watchdog: about nine times the expected run
  initial begin
    #(3000 * 100);
    n_mismatch++;
    complete_run();
  end
endmodule
